// ==== hw/flash_init_pkg.sv ====
package flash_init_pkg;

  // ==========================================================
  // Client partition layout
  localparam int             NUM_CLIENTS     = 2;
  localparam int             CLIENT_IDX_W    = 1;
  localparam int             WORD_W          = 9;
  localparam int             ADDR_W          = 8;
  localparam int             MEM_DEPTH       = 64;
  localparam int             MEM_IDX_W       = 6;
  // Start address and word count per client, client 0 in the low byte
  localparam logic [15:0]    CLIENT_START_PK = 16'h2000;
  localparam logic [15:0]    CLIENT_WORDS_PK = 16'h1020;
  // Per-client options: save enabled and all nine bits kept for client 0 only
  localparam logic [1:0]     CLIENT_SAVE_EN  = 2'h1;
  localparam logic [1:0]     CLIENT_WIDE     = 2'h1;
  localparam logic [1:0]     PROTECT_RST     = 2'h0;
  localparam logic [8:0]     WORD_ZERO       = 9'h000;

  // ==========================================================
  // Timing
  localparam int             CLK_FREQ_KHZ    = 25000;
  localparam int             INIT_MAX_KHZ    = 10000;
  localparam int             STEP_CYCLES     = (CLK_FREQ_KHZ + INIT_MAX_KHZ - 1) / INIT_MAX_KHZ;
  localparam int             STEP_CNT_W      = 2;
  localparam logic [2:0]     SAVE_DONE_STEPS = 3'h4;

  // ==========================================================
  // Register map (byte offsets) and fields
  localparam logic [7:0]     REG_STATUS      = 8'h00;
  localparam logic [7:0]     REG_MEM_ADDR    = 8'h04;
  localparam logic [7:0]     REG_MEM_DATA    = 8'h08;
  localparam logic [7:0]     REG_PROTECT     = 8'h0C;
  localparam logic [7:0]     REG_SAVE_COUNT  = 8'h10;
  localparam int             ST_DONE_BIT     = 0;
  localparam int             ST_BUSY_BIT     = 1;
  localparam int             ST_SAVING_BIT   = 2;
  localparam int             ST_CLIENT_LSB   = 4;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_LOAD      = 3'b001,
    ST_LOAD_END  = 3'b010,
    ST_SAVE_ADDR = 3'b011,
    ST_SAVE_CAP  = 3'b100,
    ST_SAVE_HOLD = 3'b101,
    ST_WAIT_REL  = 3'b110
  } seq_state_t;

endpackage

// ==== hw/step_divider.sv ====
`timescale 1ns/100ps
// ==========================================================
// One-cycle step pulse at or below the initialization rate
module step_divider (
  input  wire logic clock_i,
  input  wire logic resetn_i,
  output logic      step_o
);
  import flash_init_pkg::*;

  logic [STEP_CNT_W-1:0] cnt_r;

  // Count STEP_CYCLES clocks per pulse
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r  <= '0;
      step_o <= 1'b0;
    end else if (cnt_r == STEP_CNT_W'(STEP_CYCLES - 1)) begin
      cnt_r  <= '0;
      step_o <= 1'b1;
    end else begin
      cnt_r  <= STEP_CNT_W'(cnt_r + 1'b1);
      step_o <= 1'b0;
    end
  end
endmodule // step_divider

// ==== hw/pin_sync.sv ====
`timescale 1ns/100ps
// ==========================================================
// Two-flop synchroniser for pin inputs
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule // pin_sync

// ==== hw/flash_init_client_save.sv ====
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
// ==========================================================
module flash_init_client_save (
  input  wire logic                                          clock_i,
  input  wire logic                                          resetn_i,
  input  wire logic                                          wb_cyc_i,
  input  wire logic                                          wb_stb_i,
  input  wire logic                                          wb_we_i,
  input  wire logic [7:0]                                    wb_adr_i,
  input  wire logic [3:0]                                    wb_sel_i,
  input  wire logic [31:0]                                   wb_dat_i,
  output logic      [31:0]                                   wb_dat_o,
  output logic                                               wb_ack_o,
  input  wire logic                                          init_power_up_i,
  output logic                                               init_done_o,
  output logic      [flash_init_pkg::WORD_W-1:0]             init_data_o,
  output logic      [flash_init_pkg::ADDR_W-1:0]             init_addr_o,
  output logic      [flash_init_pkg::NUM_CLIENTS-1:0]        client_select_o,
  input  wire logic                                          client_update_i,
  input  wire logic [flash_init_pkg::NUM_CLIENTS-1:0]        save_request_i,
  input  wire logic [flash_init_pkg::NUM_CLIENTS*flash_init_pkg::WORD_W-1:0] save_data_i,
  output logic                                               save_complete_o
);
  import flash_init_pkg::*;

  localparam int SYNC_W = 2 + NUM_CLIENTS + NUM_CLIENTS * WORD_W;

  // ==========================================================
  // Pin synchronisers and step divider
  logic                          step_en;
  logic                          pwr_up_s;
  logic                          update_s;
  logic [NUM_CLIENTS-1:0]        save_req_s;
  logic [NUM_CLIENTS*WORD_W-1:0] save_data_s;

  pin_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .async_i  ({init_power_up_i, client_update_i, save_request_i, save_data_i}),
    .sync_o   ({pwr_up_s, update_s, save_req_s, save_data_s})
  );

  // All sequencing advances on this pulse only
  step_divider u_step (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .step_o   (step_en)
  );

  // ==========================================================
  // Sequencer state
  seq_state_t               state_r;
  logic [CLIENT_IDX_W-1:0]  client_r;
  logic [ADDR_W-1:0]        offset_r;
  logic [2:0]               hold_r;
  logic [WORD_W-1:0]        mem_r [MEM_DEPTH];
  logic [NUM_CLIENTS-1:0]   protect_r;
  logic [MEM_IDX_W-1:0]     wb_idx_r;
  logic [7:0]               save_count_r;

  logic [ADDR_W-1:0]        cur_start;
  logic [ADDR_W-1:0]        cur_words;
  logic [ADDR_W-1:0]        cur_addr;
  logic [WORD_W-1:0]        cur_din;
  logic [WORD_W-1:0]        cur_store;
  logic                     last_word;
  logic                     last_client;
  logic                     save_ok;
  logic [NUM_CLIENTS-1:0]   sel_onehot;

  // Current client's partition and position
  always_comb begin
    cur_start   = CLIENT_START_PK[client_r * ADDR_W +: ADDR_W];
    cur_words   = CLIENT_WORDS_PK[client_r * ADDR_W +: ADDR_W];
    cur_addr    = ADDR_W'(cur_start + offset_r);
    last_word   = (offset_r == ADDR_W'(cur_words - 8'h01));
    last_client = (client_r == CLIENT_IDX_W'(NUM_CLIENTS - 1));
    save_ok     = CLIENT_SAVE_EN[client_r] & save_req_s[client_r];
    cur_din     = save_data_s[client_r * WORD_W +: WORD_W];
    cur_store   = CLIENT_WIDE[client_r] ? cur_din : {1'b0, cur_din[7:0]};
    sel_onehot  = '0;
    sel_onehot[client_r] = 1'b1;
  end

  // Main sequencer: load walks all clients, save walks requesting save-enabled ones
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r  <= ST_IDLE;
      client_r <= '0;
      offset_r <= '0;
      hold_r   <= '0;
    end else if (step_en) begin
      unique case (state_r)
        ST_IDLE: begin
          client_r <= '0;
          offset_r <= '0;
          hold_r   <= '0;
          if (pwr_up_s && !init_done_o) begin
            state_r <= ST_LOAD;
          end else if (update_s && init_done_o) begin
            state_r <= ST_SAVE_ADDR;
          end
        end
        ST_LOAD: begin
          if (!last_word) begin
            offset_r <= ADDR_W'(offset_r + 8'h01);
          end else if (!last_client) begin
            client_r <= CLIENT_IDX_W'(client_r + 1'b1);
            offset_r <= '0;
          end else begin
            state_r <= ST_LOAD_END;
          end
        end
        ST_LOAD_END: begin
          state_r <= ST_IDLE;
        end
        ST_SAVE_ADDR: begin
          if (save_ok) begin
            state_r <= ST_SAVE_CAP;
          end else if (!last_client) begin
            client_r <= CLIENT_IDX_W'(client_r + 1'b1);
          end else begin
            state_r <= ST_SAVE_HOLD;
          end
        end
        ST_SAVE_CAP: begin
          state_r <= ST_SAVE_ADDR;
          if (!last_word) begin
            offset_r <= ADDR_W'(offset_r + 8'h01);
          end else if (!last_client) begin
            client_r <= CLIENT_IDX_W'(client_r + 1'b1);
            offset_r <= '0;
          end else begin
            state_r <= ST_SAVE_HOLD;
          end
        end
        ST_SAVE_HOLD: begin
          hold_r <= 3'(hold_r + 1'b1);
          if (hold_r == 3'(SAVE_DONE_STEPS - 1'b1)) begin
            state_r <= ST_WAIT_REL;
          end
        end
        ST_WAIT_REL: begin
          if (!update_s) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Client-facing outputs, all registered on step edges
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      client_select_o <= '0;
      init_addr_o     <= '0;
      init_data_o     <= WORD_ZERO;
    end else if (step_en) begin
      unique case (state_r)
        ST_LOAD: begin
          client_select_o <= sel_onehot;
          init_addr_o     <= cur_addr;
          init_data_o     <= mem_r[cur_addr[MEM_IDX_W-1:0]];
        end
        ST_SAVE_ADDR: begin
          client_select_o <= save_ok ? sel_onehot : '0;
          init_addr_o     <= cur_addr;
        end
        ST_SAVE_CAP: begin
          if (last_word) begin
            client_select_o <= '0;
          end
        end
        default: begin
          client_select_o <= '0;
        end
      endcase
    end
  end

  // Done flag and save-complete pulse
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      init_done_o     <= 1'b0;
      save_complete_o <= 1'b0;
    end else if (step_en) begin
      if (state_r == ST_LOAD_END) begin
        init_done_o <= 1'b1;
      end else if (state_r == ST_IDLE && !pwr_up_s) begin
        init_done_o <= 1'b0;
      end
      save_complete_o <= (state_r == ST_SAVE_HOLD) &&
                         (hold_r != 3'(SAVE_DONE_STEPS - 1'b1));
    end
  end

  // ==========================================================
  // Partition protection per client
  logic [NUM_CLIENTS-1:0] prot_hit;
  logic                   wb_blocked;

  for (genvar c = 0; c < NUM_CLIENTS; c++) begin : g_prot
    localparam logic [ADDR_W-1:0] C_START = CLIENT_START_PK[c * ADDR_W +: ADDR_W];
    localparam logic [ADDR_W-1:0] C_WORDS = CLIENT_WORDS_PK[c * ADDR_W +: ADDR_W];
    logic [ADDR_W-1:0] idx_ext;
    assign idx_ext     = ADDR_W'(wb_idx_r);
    assign prot_hit[c] = protect_r[c] && (idx_ext >= C_START) &&
                         (idx_ext < ADDR_W'(C_START + C_WORDS));
  end

  assign wb_blocked = (|prot_hit) || (state_r != ST_IDLE);

  // ==========================================================
  // Wishbone slave
  logic wb_req;
  logic wb_wr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;

  // Single-cycle ack, dropped after one cycle
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Registered read data, zero for unmapped offsets
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= '0;
      unique case (wb_adr_i)
        REG_STATUS: begin
          wb_dat_o[ST_DONE_BIT]   <= init_done_o;
          wb_dat_o[ST_BUSY_BIT]   <= (state_r != ST_IDLE);
          wb_dat_o[ST_SAVING_BIT] <= (state_r >= ST_SAVE_ADDR);
          wb_dat_o[ST_CLIENT_LSB +: CLIENT_IDX_W] <= client_r;
        end
        REG_MEM_ADDR: begin
          wb_dat_o[MEM_IDX_W-1:0] <= wb_idx_r;
        end
        REG_MEM_DATA: begin
          wb_dat_o[WORD_W-1:0] <= (|prot_hit) ? WORD_ZERO : mem_r[wb_idx_r];
        end
        REG_PROTECT: begin
          wb_dat_o[NUM_CLIENTS-1:0] <= protect_r;
        end
        REG_SAVE_COUNT: begin
          wb_dat_o[7:0] <= save_count_r;
        end
        default: begin
          wb_dat_o <= '0;
        end
      endcase
    end
  end

  // Software-written control: index pointer and protection mask
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_idx_r  <= '0;
      protect_r <= PROTECT_RST;
    end else if (wb_wr && wb_sel_i[0]) begin
      if (wb_adr_i == REG_MEM_ADDR) begin
        wb_idx_r <= wb_dat_i[MEM_IDX_W-1:0];
      end else if (wb_adr_i == REG_MEM_DATA) begin
        wb_idx_r <= MEM_IDX_W'(wb_idx_r + 1'b1);
      end else if (wb_adr_i == REG_PROTECT) begin
        protect_r <= wb_dat_i[NUM_CLIENTS-1:0];
      end
    end
  end

  // Partition storage: save capture, else software fill when idle and the word's partition is unprotected
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i] <= WORD_ZERO;
      end
    end else if (step_en && state_r == ST_SAVE_CAP) begin
      mem_r[init_addr_o[MEM_IDX_W-1:0]] <= cur_store;
    end else if (wb_wr && wb_adr_i == REG_MEM_DATA && wb_sel_i[0] && !wb_blocked) begin
      mem_r[wb_idx_r][7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) begin
        mem_r[wb_idx_r][8] <= wb_dat_i[8];
      end
    end
  end

  // Count of words captured by saves
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      save_count_r <= '0;
    end else if (step_en && state_r == ST_SAVE_CAP) begin
      save_count_r <= 8'(save_count_r + 1'b1);
    end
  end

endmodule // flash_init_client_save

// ==== dv/flash_init_client_save_chk.sv ====
`timescale 1ns/100ps
// ==========================================================
// Port checker for the client session sequencer
module flash_init_client_save_chk (
  input wire logic                                   clock_i,
  input wire logic                                   resetn_i,
  input wire logic                                   wb_cyc_i,
  input wire logic                                   wb_stb_i,
  input wire logic                                   wb_ack_o,
  input wire logic                                   init_power_up_i,
  input wire logic                                   init_done_o,
  input wire logic [flash_init_pkg::ADDR_W-1:0]      init_addr_o,
  input wire logic [flash_init_pkg::NUM_CLIENTS-1:0] client_select_o,
  input wire logic                                   client_update_i,
  input wire logic                                   save_complete_o
);
  import flash_init_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // ==========================================================
  // Client session and Wishbone ack checks
  one_client_a: assert property ($onehot0(client_select_o))
    else $error("two selects active");
  sel_in_session_a: assert property (client_select_o != 2'h0 |->
    (init_power_up_i && !init_done_o) || client_update_i) else $error("select outside session");
  addr_rate_a: assert property ($changed(init_addr_o) && client_select_o != 2'h0
    |=> $stable(init_addr_o) [*2]) else $error("address stepped too fast");
  addr_ascend_a: assert property ($past(client_select_o) != 2'h0
    && client_select_o == $past(client_select_o) && $changed(init_addr_o)
    |-> init_addr_o == $past(init_addr_o) + 8'h01) else $error("address not ascending");
  first_hold_a: assert property ($past(client_select_o) == 2'h1 && client_select_o != 2'h1
    |-> $past(init_addr_o) == 8'h1F) else $error("client 0 released early");
  second_hold_a: assert property ($past(client_select_o) == 2'h2 && client_select_o != 2'h2
    |-> $past(init_addr_o) == 8'h2F) else $error("client 1 released early");
  complete_len_a: assert property ($rose(save_complete_o)
    |=> save_complete_o [*8] ##1 !save_complete_o) else $error("complete pulse length");
  complete_cause_a: assert property ($rose(save_complete_o)
    |-> client_update_i && init_done_o) else $error("complete without save");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus not acknowledged");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");

  // Main scenarios reached
  load_c: cover property ($rose(init_done_o));
  save_c: cover property ($rose(save_complete_o));
  second_c: cover property (client_select_o == 2'h2);
endmodule // flash_init_client_save_chk

bind flash_init_client_save flash_init_client_save_chk u_chk (.clock_i(clock_i),
  .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .init_power_up_i(init_power_up_i), .init_done_o(init_done_o), .init_addr_o(init_addr_o),
  .client_select_o(client_select_o), .client_update_i(client_update_i),
  .save_complete_o(save_complete_o));

// ==== dv/client_mem_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// Fabric client RAM written by load, read by save
module client_mem_model (
  input  wire logic                                                          clock_i,
  input  wire logic                                                          init_power_up_i,
  input  wire logic                                                          init_done_i,
  input  wire logic [flash_init_pkg::WORD_W-1:0]                             init_data_i,
  input  wire logic [flash_init_pkg::ADDR_W-1:0]                             init_addr_i,
  input  wire logic [flash_init_pkg::NUM_CLIENTS-1:0]                        client_select_i,
  input  wire logic                                                          client_update_i,
  output logic      [flash_init_pkg::NUM_CLIENTS*flash_init_pkg::WORD_W-1:0] save_data_o
);
  import flash_init_pkg::*;
  logic [WORD_W-1:0] ram_r [MEM_DEPTH];

  // Load writes on every clock while a select is high
  always @(posedge clock_i) begin
    if (init_power_up_i && !init_done_i && client_select_i != 2'h0) begin
      ram_r[init_addr_i[MEM_IDX_W-1:0]] <= init_data_i;
    end
  end

  // Unpipelined read; bus rests at zero outside its session
  always_comb begin
    for (int c = 0; c < NUM_CLIENTS; c++) begin
      save_data_o[c*WORD_W +: WORD_W] = (client_update_i && client_select_i[c]) ?
        ram_r[init_addr_i[MEM_IDX_W-1:0]] : WORD_ZERO;
    end
  end
endmodule // client_mem_model

// ==== dv/flash_init_client_save_tb_top.sv ====
`timescale 1ns/100ps
// ==========================================================
// Bench: fill partition, load, save, protect
module flash_init_client_save_tb_top;
  import flash_init_pkg::*;
  logic                          clock_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]                    wb_adr_i;
  logic [3:0]                    wb_sel_i;
  logic [31:0]                   wb_dat_i, wb_dat_o, rd;
  logic                          init_power_up_i, init_done_o, client_update_i, save_complete_o;
  logic [WORD_W-1:0]             init_data_o;
  logic [ADDR_W-1:0]             init_addr_o;
  logic [NUM_CLIENTS-1:0]        client_select_o, save_request_i;
  logic [NUM_CLIENTS*WORD_W-1:0] save_data_i;
  int                            n_errors, n_compared, seed, i;
  int                            exp_mem [64];

  // 25 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  flash_init_client_save u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .init_power_up_i(init_power_up_i), .init_done_o(init_done_o), .init_data_o(init_data_o),
    .init_addr_o(init_addr_o), .client_select_o(client_select_o),
    .client_update_i(client_update_i), .save_request_i(save_request_i),
    .save_data_i(save_data_i), .save_complete_o(save_complete_o));

  client_mem_model u_client (.clock_i(clock_i), .init_power_up_i(init_power_up_i),
    .init_done_i(init_done_o), .init_data_i(init_data_o), .init_addr_i(init_addr_o),
    .client_select_i(client_select_o), .client_update_i(client_update_i),
    .save_data_o(save_data_i));

  // ==========================================================
  // Verdict and compare
  task automatic stop_test();
    $display("counts: %0d compared, %0d mismatched", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single Wishbone cycle, read data left in rd
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clock_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      chk("wb_ack", 32'h1, {31'h0, wb_ack_o});
      stop_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd_mem(input int a, input int exp);
    wb(1'b1, REG_MEM_ADDR, a);
    wb(1'b0, REG_MEM_DATA, 32'h0);
    chk("mem_data", exp, rd);
  endtask

  // Bounded wait for done (0) or save complete (1)
  task automatic wait_out(input int which);
    int k;
    for (k = 0; k < 400; k++) begin
      @(posedge clock_i);
      if ((which == 0 ? init_done_o : save_complete_o) === 1'b1) break;
    end
    if (k >= 400) begin
      chk("wait_out", 32'h1, 32'h0);
      stop_test();
    end
  endtask

  initial begin
    repeat (100000) @(posedge clock_i);
    chk("run_time", 32'h0, 32'h1);
    stop_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {n_errors, n_compared, seed} = {32'h0, 32'h0, 32'hAD27};
    {resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {init_power_up_i, client_update_i, save_request_i} = '0;
    wb_sel_i = 4'hF;
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    chk("idle_outs", 32'h0, {client_select_o, init_done_o, save_complete_o});
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset finished");
    wb(1'b1, REG_MEM_ADDR, 32'h0);
    for (i = 0; i < 48; i++) begin
      exp_mem[i] = $random(seed) & 32'h1FF;
      wb(1'b1, REG_MEM_DATA, exp_mem[i]);
    end
    rd_mem(5, exp_mem[5]);
    $display("test fill finished");
    init_power_up_i <= 1'b1;
    wait_out(0);
    for (i = 0; i < 48; i++) chk("client_word", exp_mem[i], u_client.ram_r[i]);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status_done", 32'h1, {31'h0, rd[ST_DONE_BIT]});
    $display("test load finished");
    for (i = 0; i < 32; i++) begin
      exp_mem[i] = $random(seed) & 32'h1FF;
      u_client.ram_r[i] = exp_mem[i][8:0];
    end
    client_update_i <= 1'b1;
    save_request_i <= 2'h3;
    wait_out(1);
    client_update_i <= 1'b0;
    save_request_i <= 2'h0;
    for (i = 0; i < 48; i++) rd_mem(i, exp_mem[i]);
    wb(1'b0, REG_SAVE_COUNT, 32'h0);
    chk("save_count", 32'd32, rd);
    $display("test save finished");
    wb(1'b1, REG_PROTECT, 32'h1);
    wb(1'b0, REG_PROTECT, 32'h0);
    chk("protect", 32'h1, rd);
    rd_mem(0, 0);
    wb(1'b1, REG_MEM_DATA, 32'h1AA);
    wb(1'b1, REG_PROTECT, 32'h0);
    rd_mem(0, exp_mem[0]);
    $display("test protect finished");
    init_power_up_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("done_clear", 32'h0, rd);
    $display("test release finished");
    stop_test();
  end
endmodule // flash_init_client_save_tb_top
